// file: mtd_regs.svh
// Register offsets, field positions, reset values and widths for motion threshold detect
`ifndef MTD_REGS_SVH
`define MTD_REGS_SVH

// ****************************************************************
// Register offsets
// ****************************************************************
`define MTD_ACT_THR_HIGH_ADDR   8'h20
`define MTD_ACT_THR_LOW_ADDR    8'h21
`define MTD_ACT_COUNT_ADDR      8'h22
`define MTD_INACT_THR_HIGH_ADDR 8'h23
`define MTD_INACT_THR_LOW_ADDR  8'h24
`define MTD_INACT_COUNT_HI_ADDR 8'h25
`define MTD_INACT_COUNT_LO_ADDR 8'h26

// ****************************************************************
// Field layout and reset values
// ****************************************************************
`define MTD_HIGH_FIELD_MASK     8'h7F
`define MTD_LOW_FIELD_MASK      8'hFC
`define MTD_LOW_FIELD_SHIFT     2
`define MTD_REG_RESET           8'h00
`define MTD_SAMPLE_W            14
`define MTD_THR_W               13
`define MTD_ACT_COUNT_W         8
`define MTD_INACT_COUNT_W       16
`define MTD_AXES                3
`define MTD_REG_FILE_DEPTH      8

`endif

// file: mtd_pkg.sv
// Types shared by the motion threshold detect block
package mtd_pkg;

	typedef logic [7:0] mtd_byte_t;

	// Register access request from the documented register port
	typedef struct packed {
		logic      wr_en;
		logic      rd_en;
		mtd_byte_t addr;
		mtd_byte_t wdata;
	} mtd_reg_req_s;

	// Event outputs
	typedef struct packed {
		logic act;
		logic inact;
	} mtd_event_s;

	typedef enum logic [1:0] {
		MTD_RUN_IDLE    = 2'b01,
		MTD_RUN_COUNTING = 2'b10
	} mtd_run_e;

endpackage

// file: mtd_reg_mem.sv
// Small register store with registered read data
`timescale 1ns/1ps
module mtd_reg_mem
	import mtd_pkg::*;
#(
	parameter int DEPTH = 8
) (
	input  wire logic                     core_clk_i,
	input  wire logic                     rst_i,
	input  wire logic                     wr_en_i,
	input  wire logic [$clog2(DEPTH)-1:0] wr_idx_i,
	input  wire logic [7:0]               wr_data_i,
	input  wire logic [$clog2(DEPTH)-1:0] rd_idx_i,
	output logic      [7:0]               rd_data_o,
	output logic      [DEPTH*8-1:0]       all_o
);

	logic [7:0] mem_reg [DEPTH];
	logic [7:0] rd_data_reg;

	genvar g;
	generate
		for (g = 0; g < DEPTH; g++) begin : g_word
			always_ff @(posedge core_clk_i) begin
				if (rst_i) begin
					mem_reg[g] <= 8'h00;
				end else if (wr_en_i && wr_idx_i == g) begin
					mem_reg[g] <= wr_data_i;
				end
			end
			assign all_o[g*8 +: 8] = mem_reg[g];
		end
	endgenerate

	always_ff @(posedge core_clk_i) begin
		if (rst_i) begin
			rd_data_reg <= 8'h00;
		end else begin
			rd_data_reg <= mem_reg[rd_idx_i];
		end
	end

	assign rd_data_o = rd_data_reg;

endmodule

// file: mtd_motion_threshold_detect.sv
// Activity and inactivity threshold detection with its configuration registers
`timescale 1ns/1ps
`include "mtd_regs.svh"

// Operation
// - Activity compares the absolute value of each 14-bit signed axis sample to the 13-bit threshold.
// - Activity threshold bits 5..0 sit in bits 7..2 of its low register, bits 1..0 read zero.
// - Activity threshold bits 12..6 sit in bits 6..0 of its high register, bit 7 reads zero.
// - Thresholds are compared as raw codes with no rescaling for the measurement range.
// - Activity fires after the 8-bit count of consecutive samples with any axis above threshold.
// - A sample is inactive only when its magnitude is strictly below the inactivity threshold.
// - Inactivity threshold bits 12..6 sit in bits 6..0 of its high register, bit 7 reserved.
// - Threshold and activity count registers reset to zero and their fields are read-write.
// - Inactivity threshold low register follows the high one, bits 7..2 hold bits 5..0.
// - Inactivity fires after the 16-bit count of consecutive samples with all axes below.
module mtd_motion_threshold_detect
	import mtd_pkg::*;
#(
	parameter int SAMPLE_W = `MTD_SAMPLE_W,
	parameter int THR_W    = `MTD_THR_W
) (
	input  wire logic                  core_clk_i,
	input  wire logic                  rst_i,
	input  wire logic                  reg_wr_en_i,
	input  wire logic                  reg_rd_en_i,
	input  wire logic [7:0]            reg_addr_i,
	input  wire logic [7:0]            reg_wdata_i,
	output logic      [7:0]            reg_rdata_o,
	output logic                       reg_rvalid_o,
	input  wire logic                  sample_valid_i,
	input  wire logic [SAMPLE_W-1:0]   sample_x_i,
	input  wire logic [SAMPLE_W-1:0]   sample_y_i,
	input  wire logic [SAMPLE_W-1:0]   sample_z_i,
	output logic                       activity_event_o,
	output logic                       inactivity_event_o
);

	// ****************************************************************
	// Register port decode
	// ****************************************************************
	localparam int IDX_W = $clog2(`MTD_REG_FILE_DEPTH);

	function automatic logic [7:0] field_mask(input logic [7:0] addr);
		unique case (addr)
			`MTD_ACT_THR_HIGH_ADDR:   field_mask = `MTD_HIGH_FIELD_MASK;
			`MTD_INACT_THR_HIGH_ADDR: field_mask = `MTD_HIGH_FIELD_MASK;
			`MTD_ACT_THR_LOW_ADDR:    field_mask = `MTD_LOW_FIELD_MASK;
			`MTD_INACT_THR_LOW_ADDR:  field_mask = `MTD_LOW_FIELD_MASK;
			default:                  field_mask = 8'hFF;
		endcase
	endfunction

	function automatic logic in_map(input logic [7:0] addr);
		in_map = addr >= `MTD_ACT_THR_HIGH_ADDR && addr <= `MTD_INACT_COUNT_LO_ADDR;
	endfunction

	mtd_reg_req_s req;
	assign req = '{wr_en: reg_wr_en_i, rd_en: reg_rd_en_i, addr: reg_addr_i,
		wdata: reg_wdata_i};

	wire              wr_hit   = req.wr_en && in_map(req.addr);
	wire              rd_hit   = req.rd_en && in_map(req.addr);
	wire [IDX_W-1:0]  wr_idx   = IDX_W'(req.addr - `MTD_ACT_THR_HIGH_ADDR);
	// Reserved bits are never stored, so they always read zero
	wire [7:0]        wr_data  = req.wdata & field_mask(req.addr);
	// Spare top word is never written, so unmapped reads see zero
	wire [IDX_W-1:0]  rd_idx   = rd_hit ? wr_idx : IDX_W'(`MTD_REG_FILE_DEPTH - 1);
	wire [7:0]        mem_rdata;
	wire [`MTD_REG_FILE_DEPTH*8-1:0] mem_all;

	mtd_reg_mem #(
		.DEPTH(`MTD_REG_FILE_DEPTH)
	) u_mem (
		.core_clk_i(core_clk_i),
		.rst_i     (rst_i),
		.wr_en_i   (wr_hit),
		.wr_idx_i  (wr_idx),
		.wr_data_i (wr_data),
		.rd_idx_i  (rd_idx),
		.rd_data_o (mem_rdata),
		.all_o     (mem_all)
	);

	logic rvalid_reg;

	always_ff @(posedge core_clk_i) begin
		if (rst_i) begin
			rvalid_reg <= 1'b0;
		end else begin
			rvalid_reg <= req.rd_en;
		end
	end

	assign reg_rdata_o  = mem_rdata;
	assign reg_rvalid_o = rvalid_reg;

	// ****************************************************************
	// Threshold and count assembly
	// ****************************************************************
	function automatic logic [7:0] reg_at(input logic [`MTD_REG_FILE_DEPTH*8-1:0] all,
		input logic [7:0] addr);
		reg_at = all[(IDX_W'(addr - `MTD_ACT_THR_HIGH_ADDR))*8 +: 8];
	endfunction

	wire [7:0]       act_thr_high_byte   = reg_at(mem_all, `MTD_ACT_THR_HIGH_ADDR);
	wire [7:0]       act_thr_low_byte    = reg_at(mem_all, `MTD_ACT_THR_LOW_ADDR);
	wire [7:0]       inact_thr_high_byte = reg_at(mem_all, `MTD_INACT_THR_HIGH_ADDR);
	wire [7:0]       inact_thr_low_byte  = reg_at(mem_all, `MTD_INACT_THR_LOW_ADDR);
	wire [THR_W-1:0] act_thr   = {act_thr_high_byte[6:0], act_thr_low_byte[7:2]};
	wire [THR_W-1:0] inact_thr = {inact_thr_high_byte[6:0], inact_thr_low_byte[7:2]};
	wire [`MTD_ACT_COUNT_W-1:0]   act_count   = reg_at(mem_all, `MTD_ACT_COUNT_ADDR);
	wire [`MTD_INACT_COUNT_W-1:0] inact_count = {reg_at(mem_all, `MTD_INACT_COUNT_HI_ADDR),
		reg_at(mem_all, `MTD_INACT_COUNT_LO_ADDR)};

	// ****************************************************************
	// Magnitude compare
	// ****************************************************************
	// Magnitude of -8192 is 8192, one bit above any threshold
	function automatic logic [SAMPLE_W-1:0] magnitude(input logic [SAMPLE_W-1:0] s);
		magnitude = s[SAMPLE_W-1] ? SAMPLE_W'(-s) : s;
	endfunction

	wire [SAMPLE_W-1:0] samples [`MTD_AXES];
	assign samples[0] = sample_x_i;
	assign samples[1] = sample_y_i;
	assign samples[2] = sample_z_i;

	wire [`MTD_AXES-1:0] axis_above;
	wire [`MTD_AXES-1:0] axis_below;

	genvar a;
	generate
		for (a = 0; a < `MTD_AXES; a++) begin : g_axis
			// Raw code compare, range setting does not enter
			assign axis_above[a] = magnitude(samples[a]) > {1'b0, act_thr};
			assign axis_below[a] = magnitude(samples[a]) < {1'b0, inact_thr};
		end
	endgenerate

	wire sample_active   = |axis_above;
	wire sample_inactive = &axis_below;

	// ****************************************************************
	// Consecutive sample counters
	// ****************************************************************
	logic [`MTD_ACT_COUNT_W-1:0]   act_run_reg;
	logic [`MTD_ACT_COUNT_W-1:0]   act_run_next;
	logic [`MTD_INACT_COUNT_W-1:0] inact_run_reg;
	logic [`MTD_INACT_COUNT_W-1:0] inact_run_next;
	logic                          act_evt_reg;
	logic                          inact_evt_reg;
	mtd_run_e                      act_state_reg;

	// Run register saturates one below the programmed count; event fires on the sample that reaches the count
	wire act_reached   = {1'b0, act_run_reg} + 9'h001 >= {1'b0, act_count};
	wire inact_reached = {1'b0, inact_run_reg} + 17'h00001 >= {1'b0, inact_count};

	assign act_run_next = !sample_active ? '0 :
		(act_reached ? act_run_reg : act_run_reg + 8'h01);
	assign inact_run_next = !sample_inactive ? '0 :
		(inact_reached ? inact_run_reg : inact_run_reg + 16'h0001);

	always_ff @(posedge core_clk_i) begin
		if (rst_i) begin
			act_run_reg   <= '0;
			inact_run_reg <= '0;
			act_evt_reg   <= 1'b0;
			inact_evt_reg <= 1'b0;
			act_state_reg <= MTD_RUN_IDLE;
		end else if (sample_valid_i) begin
			act_run_reg   <= act_run_next;
			inact_run_reg <= inact_run_next;
			act_evt_reg   <= sample_active && act_reached;
			inact_evt_reg <= sample_inactive && inact_reached;
			act_state_reg <= sample_active ? MTD_RUN_COUNTING : MTD_RUN_IDLE;
		end else begin
			act_evt_reg   <= 1'b0;
			inact_evt_reg <= 1'b0;
		end
	end

	mtd_event_s evt;
	assign evt = '{act: act_evt_reg, inact: inact_evt_reg};
	assign activity_event_o   = evt.act;
	assign inactivity_event_o = evt.inact;

	// ****************************************************************
	// Checks
	// ****************************************************************
	chk_act_event_cause: assert property (@(posedge core_clk_i) disable iff (rst_i)
		activity_event_o |-> $past(sample_valid_i) && $past(sample_active))
		else $error("activity event without an active sample");
	chk_inact_event_cause: assert property (@(posedge core_clk_i) disable iff (rst_i)
		inactivity_event_o |-> $past(sample_valid_i) && $past(sample_inactive))
		else $error("inactivity event without an inactive sample");
	chk_act_run_reset: assert property (@(posedge core_clk_i) disable iff (rst_i)
		sample_valid_i && !sample_active |=> act_run_reg == '0)
		else $error("activity run not cleared");
	chk_inact_run_reset: assert property (@(posedge core_clk_i) disable iff (rst_i)
		sample_valid_i && !sample_inactive |=> inact_run_reg == '0)
		else $error("inactivity run not cleared");
	chk_low_reserved_zero: assert property (@(posedge core_clk_i) disable iff (rst_i)
		reg_rvalid_o && $past(req.addr) == `MTD_ACT_THR_LOW_ADDR |-> reg_rdata_o[1:0] == 2'b00)
		else $error("reserved low bits read nonzero");
	chk_high_reserved_zero: assert property (@(posedge core_clk_i) disable iff (rst_i)
		reg_rvalid_o && $past(req.addr) == `MTD_ACT_THR_HIGH_ADDR |-> reg_rdata_o[7] == 1'b0)
		else $error("reserved high bit read nonzero");
	chk_inact_high_reserved: assert property (@(posedge core_clk_i) disable iff (rst_i)
		reg_rvalid_o && $past(req.addr) == `MTD_INACT_THR_HIGH_ADDR |-> reg_rdata_o[7] == 1'b0)
		else $error("inactivity reserved bit read nonzero");
	chk_write_readback: assert property (@(posedge core_clk_i) disable iff (rst_i)
		req.wr_en && req.addr == `MTD_ACT_COUNT_ADDR ##1 !req.wr_en
		##1 req.rd_en && !req.wr_en && req.addr == `MTD_ACT_COUNT_ADDR
		|=> reg_rdata_o == $past(req.wdata, 3))
		else $error("activity count readback mismatch");
	chk_inact_low_field: assert property (@(posedge core_clk_i) disable iff (rst_i)
		reg_rvalid_o && $past(req.addr) == `MTD_INACT_THR_LOW_ADDR |-> reg_rdata_o[1:0] == 2'b00)
		else $error("inactivity low reserved bits nonzero");
	chk_strict_above: assert property (@(posedge core_clk_i) disable iff (rst_i)
		sample_active |-> magnitude(sample_x_i) > act_thr || magnitude(sample_y_i) > act_thr
		|| magnitude(sample_z_i) > act_thr)
		else $error("activity qualified without exceeding threshold");

	// Register port
	chk_rvalid_after_read: assert property (@(posedge core_clk_i) disable iff (rst_i)
		req.rd_en |=> reg_rvalid_o)
		else $error("read valid missing after a read strobe");
	chk_rvalid_only_read: assert property (@(posedge core_clk_i) disable iff (rst_i)
		!req.rd_en |=> !reg_rvalid_o)
		else $error("read valid without a read strobe");
	chk_unmapped_zero: assert property (@(posedge core_clk_i) disable iff (rst_i)
		req.rd_en && !in_map(req.addr) |=> reg_rdata_o == 8'h00)
		else $error("unmapped read returned nonzero");
	chk_reset_regs_zero: assert property (@(posedge core_clk_i) disable iff (rst_i)
		$fell(rst_i) |-> mem_all == '0)
		else $error("register not zero after reset");
	chk_act_count_field: assert property (@(posedge core_clk_i) disable iff (rst_i)
		req.wr_en && req.addr == `MTD_ACT_COUNT_ADDR |=> act_count == $past(req.wdata))
		else $error("activity count not taken from write");
	chk_act_low_field: assert property (@(posedge core_clk_i) disable iff (rst_i)
		req.wr_en && req.addr == `MTD_ACT_THR_LOW_ADDR |=> act_thr[5:0] == $past(req.wdata[7:2]))
		else $error("activity threshold low field misplaced");
	chk_act_high_field: assert property (@(posedge core_clk_i) disable iff (rst_i)
		req.wr_en && req.addr == `MTD_ACT_THR_HIGH_ADDR |=> act_thr[12:6] == $past(req.wdata[6:0]))
		else $error("activity threshold high field misplaced");
	chk_inact_high_field: assert property (@(posedge core_clk_i) disable iff (rst_i)
		req.wr_en && req.addr == `MTD_INACT_THR_HIGH_ADDR
		|=> inact_thr[12:6] == $past(req.wdata[6:0]))
		else $error("inactivity threshold high field misplaced");
	chk_inact_low_write: assert property (@(posedge core_clk_i) disable iff (rst_i)
		req.wr_en && req.addr == `MTD_INACT_THR_LOW_ADDR
		|=> inact_thr[5:0] == $past(req.wdata[7:2]))
		else $error("inactivity threshold low field misplaced");
	chk_inact_count_low: assert property (@(posedge core_clk_i) disable iff (rst_i)
		req.wr_en && req.addr == `MTD_INACT_COUNT_LO_ADDR |=> inact_count[7:0] == $past(req.wdata))
		else $error("inactivity count low byte not taken");
	chk_inact_count_high: assert property (@(posedge core_clk_i) disable iff (rst_i)
		req.wr_en && req.addr == `MTD_INACT_COUNT_HI_ADDR |=> inact_count[15:8] == $past(req.wdata))
		else $error("inactivity count high byte not taken");

	// Detection
	chk_act_idle_quiet: assert property (@(posedge core_clk_i) disable iff (rst_i)
		!sample_valid_i |=> !activity_event_o)
		else $error("activity event without a sample");
	chk_inact_idle_quiet: assert property (@(posedge core_clk_i) disable iff (rst_i)
		!sample_valid_i |=> !inactivity_event_o)
		else $error("inactivity event without a sample");
	chk_act_break_quiet: assert property (@(posedge core_clk_i) disable iff (rst_i)
		sample_valid_i && !sample_active |=> !activity_event_o)
		else $error("activity event on a quiet sample");
	chk_inact_break_quiet: assert property (@(posedge core_clk_i) disable iff (rst_i)
		sample_valid_i && !sample_inactive |=> !inactivity_event_o)
		else $error("inactivity event on a moving sample");
	chk_act_run_step: assert property (@(posedge core_clk_i) disable iff (rst_i)
		sample_valid_i && sample_active && !act_reached |=> act_run_reg == $past(act_run_reg) + 8'h01)
		else $error("activity run did not advance");
	chk_inact_run_step: assert property (@(posedge core_clk_i) disable iff (rst_i)
		sample_valid_i && sample_inactive && !inact_reached
		|=> inact_run_reg == $past(inact_run_reg) + 16'h0001)
		else $error("inactivity run did not advance");
	chk_act_short_run: assert property (@(posedge core_clk_i) disable iff (rst_i)
		sample_valid_i && sample_active && act_count <= 8'h01 |=> activity_event_o)
		else $error("activity event missing for a run of one");
	chk_inact_short_run: assert property (@(posedge core_clk_i) disable iff (rst_i)
		sample_valid_i && sample_inactive && inact_count <= 16'h0001 |=> inactivity_event_o)
		else $error("inactivity event missing for a run of one");
	chk_full_scale_active: assert property (@(posedge core_clk_i) disable iff (rst_i)
		sample_valid_i && sample_x_i == {1'b1, (SAMPLE_W-1)'(0)} |-> sample_active && !sample_inactive)
		else $error("full scale negative sample misjudged");
	chk_inact_strict_below: assert property (@(posedge core_clk_i) disable iff (rst_i)
		sample_inactive |-> magnitude(sample_x_i) < inact_thr && magnitude(sample_y_i) < inact_thr
		&& magnitude(sample_z_i) < inact_thr)
		else $error("inactivity qualified without all axes below threshold");
	chk_run_state_idle: assert property (@(posedge core_clk_i) disable iff (rst_i)
		sample_valid_i && !sample_active |=> act_state_reg == MTD_RUN_IDLE)
		else $error("activity run state not back to idle");

	cov_act_event:   cover property (@(posedge core_clk_i) disable iff (rst_i) activity_event_o);
	cov_inact_event: cover property (@(posedge core_clk_i) disable iff (rst_i)
		inactivity_event_o);
	cov_run_break:   cover property (@(posedge core_clk_i) disable iff (rst_i)
		act_state_reg == MTD_RUN_COUNTING && sample_valid_i && !sample_active);
	cov_inact_break: cover property (@(posedge core_clk_i) disable iff (rst_i)
		sample_valid_i && !sample_inactive && inact_run_reg != '0);
	cov_unmapped_rd: cover property (@(posedge core_clk_i) disable iff (rst_i)
		req.rd_en && !in_map(req.addr));

endmodule

// file: testbench.sv
// Self-checking testbench for the motion threshold detect block
`timescale 1ns/1ps
`include "mtd_regs.svh"

module testbench;
	import mtd_pkg::*;

	// ****************************************************************
	// Signals and instance
	// ****************************************************************
	logic        core_clk_i;
	logic        rst_i;
	logic        reg_wr_en_i;
	logic        reg_rd_en_i;
	logic [7:0]  reg_addr_i;
	logic [7:0]  reg_wdata_i;
	logic [7:0]  reg_rdata_o;
	logic        reg_rvalid_o;
	logic        sample_valid_i;
	logic [13:0] sample_x_i;
	logic [13:0] sample_y_i;
	logic [13:0] sample_z_i;
	logic        activity_event_o;
	logic        inactivity_event_o;
	int          fail_count;
	int          checked;
	logic [7:0]  rd_val;
	mtd_byte_t   ff_exp [7];

	mtd_motion_threshold_detect mtd_motion_threshold_detect_inst (
		.core_clk_i         (core_clk_i),
		.rst_i              (rst_i),
		.reg_wr_en_i        (reg_wr_en_i),
		.reg_rd_en_i        (reg_rd_en_i),
		.reg_addr_i         (reg_addr_i),
		.reg_wdata_i        (reg_wdata_i),
		.reg_rdata_o        (reg_rdata_o),
		.reg_rvalid_o       (reg_rvalid_o),
		.sample_valid_i     (sample_valid_i),
		.sample_x_i         (sample_x_i),
		.sample_y_i         (sample_y_i),
		.sample_z_i         (sample_z_i),
		.activity_event_o   (activity_event_o),
		.inactivity_event_o (inactivity_event_o)
	);

	initial begin
		core_clk_i = 1'b0;
		forever #2.5 core_clk_i = ~core_clk_i;
	end

	// ****************************************************************
	// Tasks
	// ****************************************************************
	task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
		checked++;
		if (seen !== exp) begin
			fail_count++;
			$display("BAD %s expected %h seen %h", name, exp, seen);
		end
	endtask

	task automatic wr(input logic [7:0] addr, input logic [7:0] data);
		@(posedge core_clk_i);
		#1;
		reg_wr_en_i = 1'b1;
		reg_addr_i  = addr;
		reg_wdata_i = data;
		@(posedge core_clk_i);
		#1;
		reg_wr_en_i = 1'b0;
	endtask

	// Read data and valid are checked in the cycle after the strobe
	task automatic rd(input logic [7:0] addr, output logic [7:0] data);
		@(posedge core_clk_i);
		#1;
		reg_rd_en_i = 1'b1;
		reg_addr_i  = addr;
		@(posedge core_clk_i);
		#1;
		reg_rd_en_i = 1'b0;
		check("rvalid", {7'h00, reg_rvalid_o}, 8'h01);
		data = reg_rdata_o;
	endtask

	// One sample, then both event pulses checked in the following cycle
	task automatic smp(input logic [13:0] x, input logic [13:0] y, input logic [13:0] z,
			input logic act, input logic inact);
		@(posedge core_clk_i);
		#1;
		sample_valid_i = 1'b1;
		sample_x_i     = x;
		sample_y_i     = y;
		sample_z_i     = z;
		@(posedge core_clk_i);
		#1;
		sample_valid_i = 1'b0;
		check("activity_event", {7'h00, activity_event_o}, {7'h00, act});
		check("inactivity_event", {7'h00, inactivity_event_o}, {7'h00, inact});
	endtask

	task automatic finish_test();
		$display("Comparisons %0d mismatches %0d", checked, fail_count);
		if (fail_count == 0 && checked > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask

	initial begin
		#20000;
		fail_count++;
		finish_test();
	end

	// ****************************************************************
	// Tests
	// ****************************************************************
	initial begin
		fail_count = 0;
		checked = 0;
		rst_i = 1'b1;
		reg_wr_en_i = 1'b0;
		reg_rd_en_i = 1'b0;
		reg_addr_i = 8'h00;
		reg_wdata_i = 8'h00;
		sample_valid_i = 1'b0;
		sample_x_i = 14'h0000;
		sample_y_i = 14'h0000;
		sample_z_i = 14'h0000;
		ff_exp = '{8'h7F, 8'hFC, 8'hFF, 8'h7F, 8'hFC, 8'hFF, 8'hFF};
		repeat (5) @(posedge core_clk_i);
		#1;
		rst_i = 1'b0;

		// Reset values, then all ones written with reserved bits dropped
		for (int i = 0; i < 7; i++) begin
			rd(8'h20 + 8'(i), rd_val);
			check("reset_value", rd_val, 8'h00);
		end
		for (int i = 0; i < 7; i++) begin
			wr(8'h20 + 8'(i), 8'hFF);
			rd(8'h20 + 8'(i), rd_val);
			check("masked_readback", rd_val, ff_exp[i]);
		end
		wr(8'h30, 8'hFF);
		rd(8'h30, rd_val);
		check("unmapped_read", rd_val, 8'h00);
		$display("Register test done");

		// Activity threshold 65 split over both registers, run of 2
		wr(`MTD_ACT_THR_HIGH_ADDR, 8'h01);
		wr(`MTD_ACT_THR_LOW_ADDR, 8'h04);
		wr(`MTD_ACT_COUNT_ADDR, 8'h02);
		wr(`MTD_INACT_THR_HIGH_ADDR, 8'h00);
		wr(`MTD_INACT_THR_LOW_ADDR, 8'h00);
		smp(14'd65, 14'd0, 14'd0, 1'b0, 1'b0);
		smp(14'd66, 14'd0, 14'd0, 1'b0, 1'b0);
		smp(14'd0, -14'sd66, 14'd0, 1'b1, 1'b0);
		smp(14'd0, 14'd0, 14'd67, 1'b1, 1'b0);
		smp(14'd0, 14'd0, 14'd0, 1'b0, 1'b0);
		smp(14'd0, 14'd0, -14'sd100, 1'b0, 1'b0);
		wr(`MTD_ACT_COUNT_ADDR, 8'h01);
		smp(14'h2000, 14'd0, 14'd0, 1'b1, 1'b0);
		$display("Activity test done");

		// Inactivity threshold 69 split over both registers, run of 3
		wr(`MTD_ACT_THR_HIGH_ADDR, 8'h7F);
		wr(`MTD_ACT_THR_LOW_ADDR, 8'hFC);
		wr(`MTD_INACT_THR_HIGH_ADDR, 8'h01);
		wr(`MTD_INACT_THR_LOW_ADDR, 8'h14);
		wr(`MTD_INACT_COUNT_HI_ADDR, 8'h00);
		wr(`MTD_INACT_COUNT_LO_ADDR, 8'h03);
		smp(14'd68, -14'sd68, 14'd0, 1'b0, 1'b0);
		smp(14'd68, 14'd0, 14'd0, 1'b0, 1'b0);
		smp(14'd0, 14'd0, 14'd69, 1'b0, 1'b0);
		smp(14'd1, 14'd1, 14'd1, 1'b0, 1'b0);
		smp(14'd2, 14'd2, 14'd2, 1'b0, 1'b0);
		smp(14'd3, -14'sd3, 14'd3, 1'b0, 1'b1);
		smp(14'd0, 14'd0, 14'd0, 1'b0, 1'b1);
		smp(14'h2000, 14'd0, 14'd0, 1'b1, 1'b0);
		smp(14'd0, 14'd0, 14'd0, 1'b0, 1'b0);
		$display("Inactivity test done");
		finish_test();
	end

endmodule
